// file: design/prbh_pkg.sv
// constants for the power and reset button handler
// Behaviour
// - running press raises SMI or config interrupt
// - running press processed within 100 us
// - soft-off wake needs 150 us assertion
// - no detection while unpowered
// - quiet time independent of debounce mode
// - long hold forces soft-off unconditionally
// - override duration selectable, default 4 s
// - up to 1.3 s added latency allowed
// - mode zero adds 16 ms debounce
// - mode one acts immediately, masks 16 ms
// - level flag before or after debounce
// - override stretched to 9-10 s while stretching
// - reset button detected, host reset starts
// - host reset held 5 to 6 ms
// - rearm after release and full running
// - reset-control bit 3 selects power cycle
// - reset button needs platform power good
package prbh_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned DEBOUNCE_US    = 16000;
  localparam int unsigned WAKE_MIN_US    = 150;
  localparam int unsigned HOST_RST_US    = 5500;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned WAKE_MIN_CYC   = WAKE_MIN_US * CLK_MHZ;
  localparam int unsigned HOST_RST_CYC   = HOST_RST_US * CLK_MHZ;
  // override base seconds per select code: 4 + 2*sel (4..18 s)
  localparam int unsigned OVR_BASE_S     = 4;
  localparam int unsigned OVR_STEP_S     = 2;
  localparam int unsigned OVR_STRETCH_S  = 10;
  localparam logic [2:0]  OVR_SEL_RESET  = 3'h0;
  localparam int unsigned RST_CTRL_PWRCYC_BIT = 3;
  typedef enum logic [1:0] {
    PRBH_OFF     = 2'h0,
    PRBH_SOFTOFF = 2'h1,
    PRBH_RUN     = 2'h3,
    PRBH_SLEEP   = 2'h2
  } prbh_state_t;
endpackage

// file: design/prbh_handler.sv
// power button and reset button handler
`timescale 1ns/1ps
`default_nettype none
module prbh_handler import prbh_pkg::*; #(
  parameter int unsigned SEC_CYC      = 100000000,
  parameter int unsigned DEBOUNCE_CNT = DEBOUNCE_CYC,
  parameter int unsigned WAKE_CNT     = WAKE_MIN_CYC,
  parameter int unsigned HRST_CNT     = HOST_RST_CYC
) (
  // clock and resume-well reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // pins
  input  wire logic       power_button_n,
  input  wire logic       reset_button_n,
  input  wire logic       platform_power_good,
  // system state from the sleep sequencer
  input  wire logic       sys_running,
  input  wire logic       sys_sleeping,
  input  wire logic       platform_reset_n,
  input  wire logic       stretch_active,
  // configuration
  input  wire logic       button_debounce_select,
  input  wire logic [2:0] override_duration_sel,
  input  wire logic       config_interrupt_select,
  input  wire logic       button_event_enable,
  input  wire logic       global_mgmt_irq_enable,
  input  wire logic [7:0] reset_control,
  // events and status
  output logic            mgmt_irq,
  output logic            config_irq,
  output logic            wake_request,
  output logic            force_soft_off,
  output logic            host_reset,
  output logic            power_cycle_reset,
  output logic            button_level_flag
);
  localparam int unsigned DBW = $clog2(DEBOUNCE_CNT + 1);
  localparam int unsigned HRW = $clog2(HRST_CNT + 1);
  localparam int unsigned OVW = 40;

  // two-stage synchronisers; while unpowered the resume-well reset holds all
  // button pins leave reset at the released level and power good leaves it low, in both modes, so the quiet time is alike
  logic [1:0] pb_s_q, rb_s_q, pg_s_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pb_s_q <= 2'h3;
      rb_s_q <= 2'h3;
      pg_s_q <= 2'h0;
    end else begin
      pb_s_q <= {pb_s_q[0], power_button_n};
      rb_s_q <= {rb_s_q[0], reset_button_n};
      pg_s_q <= {pg_s_q[0], platform_power_good};
    end
  end
  wire pb_raw = ~pb_s_q[1];
  wire rb_raw = ~rb_s_q[1];
  wire pg     = pg_s_q[1];

  // debounce: a level must stand DEBOUNCE_CNT cycles to be accepted
  logic [DBW-1:0] pb_db_cnt_q, rb_db_cnt_q;
  logic           pb_db_q, rb_db_q, pb_raw_q;
  wire pb_db_done = pb_db_cnt_q == DBW'(DEBOUNCE_CNT);
  wire rb_db_done = rb_db_cnt_q == DBW'(DEBOUNCE_CNT);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pb_db_cnt_q <= '0;
      rb_db_cnt_q <= '0;
      pb_db_q     <= 1'b0;
      rb_db_q     <= 1'b0;
      pb_raw_q    <= 1'b0;
    end else begin
      pb_raw_q    <= pb_raw;
      pb_db_cnt_q <= (pb_raw == pb_db_q) ? '0 : pb_db_done ? '0 : pb_db_cnt_q + 1'b1;
      rb_db_cnt_q <= (rb_raw == rb_db_q) ? '0 : rb_db_done ? '0 : rb_db_cnt_q + 1'b1;
      if (pb_db_done) pb_db_q <= pb_raw;
      if (rb_db_done) rb_db_q <= rb_raw;
    end
  end
  wire pb_db_rise = pb_db_done & pb_raw & ~pb_db_q;

  // fast mode: act on raw falling edge, mask further edges 16 ms
  logic [DBW-1:0] mask_cnt_q;
  wire mask_busy = mask_cnt_q != '0;
  wire pb_fast   = pb_raw & ~pb_raw_q & ~mask_busy;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) mask_cnt_q <= '0;
    else if (pb_fast) mask_cnt_q <= DBW'(DEBOUNCE_CNT);
    else if (mask_busy) mask_cnt_q <= mask_cnt_q - 1'b1;
  end

  // press event: within 100 us of pin (sync delay only) plus debounce
  wire press_evt = button_debounce_select ? pb_fast : pb_db_rise;
  // level flag source follows the debounce mode
  wire level_src = button_debounce_select ? pb_raw : pb_db_q;
  // minimum-width qualifier for wake; same in both modes except 16 ms in mode zero
  wire pb_qual   = button_debounce_select ? pb_raw : pb_db_q;

  // wake qualification counter in soft-off
  localparam int unsigned WKW = $clog2(WAKE_CNT + 1);
  logic [WKW-1:0] wake_cnt_q;
  wire in_softoff = ~sys_running & ~sys_sleeping;
  wire wake_hit   = in_softoff & pb_qual & (wake_cnt_q == WKW'(WAKE_CNT - 1));
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) wake_cnt_q <= '0;
    else if (!(in_softoff & pb_qual)) wake_cnt_q <= '0;
    else if (wake_cnt_q != WKW'(WAKE_CNT)) wake_cnt_q <= wake_cnt_q + 1'b1;
  end

  // override duration: programmed, or stretched while sleep outputs stretch
  wire [OVW-1:0] ovr_sec = stretch_active ? OVW'(OVR_STRETCH_S) :
                           OVW'(OVR_BASE_S) + OVW'(OVR_STEP_S) * OVW'(override_duration_sel);
  wire [OVW-1:0] ovr_lim = ovr_sec * OVW'(SEC_CYC);
  logic [OVW-1:0] ovr_cnt_q;
  logic           ovr_fired_q;
  wire ovr_hit = pb_db_q & (sys_running | sys_sleeping) & ~ovr_fired_q & (ovr_cnt_q >= ovr_lim);
  // counts on debounced level only; release restarts it; no power-good gate
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ovr_cnt_q   <= '0;
      ovr_fired_q <= 1'b0;
    end else begin
      ovr_cnt_q   <= pb_db_q ? ovr_cnt_q + 1'b1 : '0;
      ovr_fired_q <= pb_db_q & (ovr_fired_q | ovr_hit);
    end
  end

  // host reset from reset button; gated by power good, rearm
  logic [HRW-1:0] hr_cnt_q;
  logic           armed_q, pwrcyc_q;
  // mode one looks at the first raw low sample, mode zero waits for the debounce
  wire rb_detect = button_debounce_select ? (rb_raw & ~rb_db_q & rb_db_cnt_q == '0)
                                          : (rb_db_done & rb_raw & ~rb_db_q);
  wire hr_start  = rb_detect & pg & armed_q & (hr_cnt_q == '0);
  wire hr_busy   = hr_cnt_q != '0;
  wire rearm     = ~rb_db_q & sys_running & platform_reset_n & ~hr_busy;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hr_cnt_q <= '0;
      armed_q  <= 1'b1;
      pwrcyc_q <= 1'b0;
    end else begin
      if (hr_start) hr_cnt_q <= HRW'(HRST_CNT); // 5.5 ms, independent of pin
      else if (hr_busy) hr_cnt_q <= hr_cnt_q - 1'b1;
      if (hr_start) armed_q <= 1'b0;
      else if (rearm) armed_q <= 1'b1;
      if (hr_start) pwrcyc_q <= reset_control[RST_CTRL_PWRCYC_BIT];
    end
  end

  // registered outputs
  wire irq_sel_cfg = config_interrupt_select & button_event_enable;
  wire irq_sel_smi = ~config_interrupt_select & global_mgmt_irq_enable;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mgmt_irq          <= 1'b0;
      config_irq        <= 1'b0;
      wake_request      <= 1'b0;
      force_soft_off    <= 1'b0;
      host_reset        <= 1'b0;
      power_cycle_reset <= 1'b0;
      button_level_flag <= 1'b0;
    end else begin
      mgmt_irq          <= press_evt & sys_running & irq_sel_smi;
      config_irq        <= press_evt & sys_running & irq_sel_cfg;
      wake_request      <= wake_hit;
      force_soft_off    <= ovr_hit;
      host_reset        <= hr_busy & ~pwrcyc_q;
      power_cycle_reset <= hr_busy & pwrcyc_q;
      button_level_flag <= level_src;
    end
  end

  // assertions
  a_hr_len_fixed: assert property (@(posedge ref_clk) disable iff (reset)
    hr_start |=> hr_busy [*8]) else $error("host reset ended early");
  a_hr_pg_gate: assert property (@(posedge ref_clk) disable iff (reset)
    hr_start |-> pg) else $error("reset without power good");
  a_hr_no_rearm: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(armed_q) |-> !hr_start) else $error("rearm violated");
  a_pwrcyc_select: assert property (@(posedge ref_clk) disable iff (reset)
    hr_start |=> pwrcyc_q == $past(reset_control[RST_CTRL_PWRCYC_BIT]))
    else $error("power cycle select wrong");
  a_irq_run_only: assert property (@(posedge ref_clk) disable iff (reset)
    (mgmt_irq | config_irq) |-> $past(sys_running)) else $error("irq outside running");
  a_irq_exclusive: assert property (@(posedge ref_clk) disable iff (reset)
    !(mgmt_irq & config_irq)) else $error("both interrupts raised");
  a_ovr_restart: assert property (@(posedge ref_clk) disable iff (reset)
    !pb_db_q |=> ovr_cnt_q == '0) else $error("override not restarted");
  a_ovr_needs_lvl: assert property (@(posedge ref_clk) disable iff (reset)
    force_soft_off |-> $past(pb_db_q) && $past(ovr_cnt_q >= ovr_lim))
    else $error("override early");
  a_fast_mask: assert property (@(posedge ref_clk) disable iff (reset)
    pb_fast |=> !pb_fast [*8]) else $error("edge not masked");
  a_level_flag: assert property (@(posedge ref_clk) disable iff (reset)
    button_level_flag == $past(level_src)) else $error("level flag wrong");
  a_wake_min: assert property (@(posedge ref_clk) disable iff (reset)
    wake_request |-> $past(pb_qual, 2)) else $error("wake too short");

  // further checks on state gating, pulse widths and mode selection
  a_wake_softoff: assert property (@(posedge ref_clk) disable iff (reset)
    wake_request |-> $past(in_softoff)) else $error("wake outside soft-off");
  a_force_state: assert property (@(posedge ref_clk) disable iff (reset)
    force_soft_off |-> $past(sys_running | sys_sleeping)) else $error("force in wrong state");
  a_force_once: assert property (@(posedge ref_clk) disable iff (reset)
    force_soft_off |=> !force_soft_off) else $error("force repeated");
  a_ovr_stretch: assert property (@(posedge ref_clk) disable iff (reset)
    force_soft_off & $past(stretch_active) |->
    $past(ovr_cnt_q) >= OVW'(OVR_STRETCH_S) * OVW'(SEC_CYC)) else $error("stretch ignored");
  a_reset_kind_excl: assert property (@(posedge ref_clk) disable iff (reset)
    !(host_reset & power_cycle_reset)) else $error("both reset kinds raised");
  a_hr_count_down: assert property (@(posedge ref_clk) disable iff (reset)
    hr_busy |=> hr_cnt_q == $past(hr_cnt_q) - 1'b1) else $error("host reset count skipped");
  a_press_mode_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (!button_debounce_select & press_evt) |-> pb_db_done) else $error("press not debounced");
  a_rb_mode_raw: assert property (@(posedge ref_clk) disable iff (reset)
    (hr_start & button_debounce_select) |-> rb_db_cnt_q == '0) else $error("reset detect late");
  a_rb_mode_deb: assert property (@(posedge ref_clk) disable iff (reset)
    (hr_start & !button_debounce_select) |-> rb_db_done) else $error("reset detect early");
  a_mgmt_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    mgmt_irq |=> !mgmt_irq) else $error("interrupt held too long");
  a_cfg_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    config_irq |=> !config_irq) else $error("config interrupt held too long");
endmodule
`default_nettype wire

// file: sim/prbh_board.sv
// board model: power and reset push buttons with pull-ups
`timescale 1ns/1ps
`default_nettype none
module prbh_board #(
  parameter int unsigned QUIET_CYC = 60
) (
  // clock and resume-well reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // press requests from the bench
  input  wire logic pb_press,
  input  wire logic rb_press,
  // button pins
  output logic      power_button_n,
  output logic      reset_button_n
);
  logic [15:0] quiet_q;
  // quiet time after resume reset, so an early power-button press reaches its pin only after QUIET_CYC cycles
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) quiet_q <= 16'h0;
    else if (quiet_q < QUIET_CYC) quiet_q <= quiet_q + 16'h1;
  end
  // a released button floats up to its pull-up level
  assign power_button_n = ~(pb_press & (quiet_q >= QUIET_CYC));
  assign reset_button_n = ~rb_press;
endmodule
`default_nettype wire

// file: sim/test_power_and_reset_button_handler.sv
// self-checking bench for the power and reset button handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_power_and_reset_button_handler;
  localparam int unsigned HRST = 50;
  // bench-driven inputs
  logic ref_clk = 1'b0, reset = 1'b1, pb_press = 1'b0, rb_press = 1'b0;
  logic pgood = 1'b1, run = 1'b1, str = 1'b0, dbs = 1'b1, cis = 1'b0, bee = 1'b0, gme = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] rctl = 8'h00;
  wire logic pb_n, rb_n, mirq, cirq, wake, force_off, hrst, pcrst, lvl;
  wire logic ev = mirq | cirq | wake | force_off | hrst | pcrst;
  int errors = 0, checked = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  prbh_board prbh_board_inst (.ref_clk(ref_clk), .reset(reset), .pb_press(pb_press),
    .rb_press(rb_press), .power_button_n(pb_n), .reset_button_n(rb_n));
  // short counts keep the run brief; sleep state and platform reset are tied
  prbh_handler #(.SEC_CYC(1000), .DEBOUNCE_CNT(20), .WAKE_CNT(10), .HRST_CNT(HRST))
  prbh_handler_inst (.ref_clk(ref_clk), .reset(reset), .power_button_n(pb_n),
    .reset_button_n(rb_n), .platform_power_good(pgood), .sys_running(run),
    .sys_sleeping(1'b0), .platform_reset_n(1'b1), .stretch_active(str),
    .button_debounce_select(dbs), .override_duration_sel(sel),
    .config_interrupt_select(cis), .button_event_enable(bee),
    .global_mgmt_irq_enable(gme), .reset_control(rctl), .mgmt_irq(mirq),
    .config_irq(cirq), .wake_request(wake), .force_soft_off(force_off),
    .host_reset(hrst), .power_cycle_reset(pcrst), .button_level_flag(lvl));
  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic drv(input logic p, input logic r);
    @(negedge ref_clk);
    pb_press = p;
    rb_press = r;
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // wait for any event output, bounded, sampled after the edge settles
  task automatic watch(input int lim, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (n < lim && ev !== 1'b1);
  endtask
  task automatic t_irq;
    int n;
    for (int i = 0; i < 3; i++) begin
      {cis, bee, gme} = (i == 0) ? 3'b110 : (i == 1) ? 3'b001 : 3'b101;
      drv(1, 0);
      watch(12, n);
      `CHK({cirq, mirq}, (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b00)
      `CHK(n <= 10, i != 2)
      drv(0, 0);
      drv(1, 0);
      watch(8, n);
      `CHK(ev, 1'b0)
      drv(0, 0);
      idle(30);
    end
    $display("test irq done");
  endtask
  task automatic t_deb;
    int n;
    dbs = 0;
    {cis, bee, gme} = 3'b110;
    drv(1, 0);
    idle(8);
    `CHK(lvl, 1'b0)
    watch(40, n);
    `CHK(cirq, 1'b1)
    `CHK(n + 8 > 20, 1'b1)
    idle(2);
    `CHK(lvl, 1'b1)
    drv(0, 0);
    idle(30);
    dbs = 1;
    drv(1, 0);
    idle(5);
    `CHK(lvl, 1'b1)
    drv(0, 0);
    idle(30);
    $display("test debounce done");
  endtask
  task automatic t_wake;
    int n;
    run = 0;
    drv(1, 0);
    idle(5);
    drv(0, 0);
    watch(20, n);
    `CHK(wake, 1'b0)
    drv(1, 0);
    watch(30, n);
    `CHK(wake, 1'b1)
    `CHK(n >= 10, 1'b1)
    drv(0, 0);
    run = 1;
    idle(30);
    $display("test wake done");
  endtask
  // long holds stand in for lock-up recovery; the first hold at each select code is cut short
  task automatic t_ovr;
    int n;
    {cis, bee, gme} = 3'b000;
    pgood = 0;
    for (int s = 0; s < 2; s++) begin
      sel = 3'(s);
      drv(1, 0);
      idle(2000);
      drv(0, 0);
      idle(30);
      drv(1, 0);
      watch(7500, n);
      `CHK(force_off, 1'b1)
      `CHK(n >= 1000 * (4 + 2 * s), 1'b1)
      `CHK(n <= 1000 * (4 + 2 * s) + 1330, 1'b1)
      drv(0, 0);
      idle(30);
    end
    sel = 3'h0;
    str = 1;
    drv(1, 0);
    watch(11500, n);
    `CHK(force_off, 1'b1)
    `CHK(n >= 9000, 1'b1)
    drv(0, 0);
    str = 0;
    pgood = 1;
    idle(30);
    $display("test override done");
  endtask
  task automatic t_rst;
    int n;
    pgood = 0;
    drv(0, 1);
    watch(30, n);
    `CHK(ev, 1'b0)
    drv(0, 0);
    pgood = 1;
    idle(30);
    for (int c = 0; c < 3; c++) begin
      rctl = (c == 1) ? 8'h08 : 8'h00;
      dbs = (c != 2);
      drv(0, 1);
      watch(40, n);
      `CHK({pcrst, hrst}, (c == 1) ? 2'b10 : 2'b01)
      `CHK(n > 20, c == 2)
      n = 0;
      while (ev === 1'b1 && n < 100) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      `CHK(n, HRST)
      watch(40, n);
      `CHK(ev, 1'b0)
      drv(0, 0);
      idle(30);
    end
    $display("test reset button done");
  endtask
  // cut a hang short well beyond the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 45000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    idle(4);
    reset = 0;
    idle(70);
    t_irq;
    t_deb;
    t_wake;
    t_ovr;
    t_rst;
    print_verdict;
  end
endmodule
`default_nettype wire
